/* File: verilog/oss_pkg.sv */
// shared constants and types for the octal switch serial control block
package oss_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CHANNELS = 8;
  localparam int FRAME_BITS = 16;
  localparam int EDGE_CNT_W = 3;
  // minimum low time of the output gate before all channels switch off in serial mode
  localparam int DISABLE_HOLD_NS = 1000;
  localparam int DISABLE_HOLD_CYCLES = (DISABLE_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int GATE_CNT_W = $clog2(DISABLE_HOLD_CYCLES + 1);
  // shortest nominal watchdog period, the others are twice and four times it
  localparam int WD_SHORT_MS = 40;
  localparam int WD_SHORT_CYCLES = WD_SHORT_MS * CLK_MHZ * 1000;
  localparam int WD_CNT_W = 26;
  // low byte of the 16-bit fault frame
  localparam int POS_FB_VALID = 7;
  localparam int POS_WARN = 6;
  localparam int POS_PERR = 5;
  localparam int POS_SUPPLY = 4;
  localparam int POS_PAR_EVEN = 3;
  localparam int POS_PAR_ODD = 2;
  localparam int POS_PAR_ALL = 1;
  localparam int POS_PAR_ALL_N = 0;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] ODD_LANES = 8'hAA;
  localparam logic [7:0] EVEN_LANES = 8'h55;
  // watchdog period select codes
  localparam logic [1:0] WD_SEL_OFF = 2'h0;
  localparam logic [1:0] WD_SEL_40 = 2'h1;
  localparam logic [1:0] WD_SEL_80 = 2'h2;
  typedef enum logic [1:0] {
    OSS_WD_OFF = 2'b00,
    OSS_WD_RUN = 2'b01,
    OSS_WD_TRIP = 2'b10
  } oss_wd_state_e;
endpackage : oss_pkg

/* File: verilog/oss_sync.sv */
// three-flop synchroniser that passes a change once the last two stages agree
`timescale 1ns/1ps
module oss_sync
  import oss_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // capture chain, stage1 is read by stage2 only
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit moves only when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= RST_VAL;
    end else begin
      dout <= (stage2 & stage3) | (dout & (stage2 ^ stage3));
    end
  end
endmodule : oss_sync

/* File: verilog/oss_ctrl.sv */
// serial control, diagnostics and watchdog of an eight-channel power switch
// Overview of operation
// - Interface select high means serial control; low means parallel channel inputs.
// - Serial output is undriven while select is high, shows fault MSB after fall.
// - Bits sampled on clock rise, shifted on clock fall, MSB first.
// - Bits shift in and out only while select is low.
// - Select fall freezes the fault frame and enables the serial output.
// - Select rise evaluates the last frame and drives channel outputs.
// - Extra bits: last frame evaluated, earlier ones leave after fault bits.
// - Frame length select low gives 8-bit frames, high gives 16-bit.
// - In serial mode, gate held low for the hold time switches all outputs off.
// - Case warning pin and bit follow case overtemperature, never latched.
// - Fault pin low while an enabled channel is in junction overtemperature.
// - Fault pin low and parity bit set on bad parity or length.
// - In 16-bit mode a status bit reports supply good.
// - Watchdog expiry forces outputs off until the next kick pulse and a new frame after it.
// - Period select gives off, 40, 80 or 160 ms watchdog timeouts.
// - In 8-bit mode command bit n drives channel n, one means on.
// - Overheat flags latch on event, clear at each select rise.
// - 16-bit command: channels in upper byte, parity nibble at bottom.
// - Command parity: even lanes, odd lanes, all eight, inverted all.
// - 16-bit fault frame: flags, feedback, warning, parity error, supply, parity.
// - Fault parity covers flags plus status bits on odd and even lanes.
// - Feedback valid rises above 90 percent after a good frame, clears below 80.
`timescale 1ns/1ps
module oss_ctrl
  import oss_pkg::*;
#(
  parameter int WD_CYCLES = WD_SHORT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic interface_select,
  input wire logic frame_length_select,
  input wire logic output_gate,
  input wire logic watchdog_kick,
  input wire logic [1:0] watchdog_period_select,
  input wire logic [CHANNELS-1:0] parallel_inputs,
  input wire logic [CHANNELS-1:0] junction_overheat,
  input wire logic case_hot,
  input wire logic supply_good,
  input wire logic fb_above_90,
  input wire logic fb_below_80,
  output logic [CHANNELS-1:0] channel_out,
  output logic fault_pin_out,
  output logic fault_pin_oe,
  output logic warn_pin_out,
  output logic warn_pin_oe,
  output logic [CHANNELS-1:0] channel_overheat_flags,
  output logic parity_error_flag,
  output logic regulator_feedback_valid
);
  // link domain state
  logic [FRAME_BITS-1:0] rx_shift;
  logic [FRAME_BITS-1:0] tx_shift;
  logic [EDGE_CNT_W-1:0] edge_cnt;
  logic pos_started, neg_started, frame_tog;
  // synchronised inputs
  logic ss_n_s, serial_s, mode16_s, gate_s, kick_s;
  logic [1:0] wd_sel_s;
  logic [CHANNELS-1:0] par_s, ot_s;
  logic case_hot_s, supply_s, fb_high_s, fb_low_s, tog_s;
  // system domain state
  logic ss_prev, tog_seen, kick_prev;
  logic [CHANNELS-1:0] cmd;
  logic [FRAME_BITS-1:0] tx_word;
  logic [GATE_CNT_W-1:0] gate_cnt;
  logic [WD_CNT_W-1:0] wd_cnt, wd_limit;
  oss_wd_state_e wd_state;
  // decoded frame
  logic frame_end, frame_ok, gate_off, wd_trip, kick_end;
  logic [CHANNELS-1:0] cmd_new;
  logic [3:0] cmd_par, fault_status, fault_par;

  // all pin inputs except sclk and sdi, and the link toggle, cross through one synchroniser bank
  oss_sync #(
    .WIDTH(28),
    .RST_VAL(28'h9800000) // select, gate and kick rest high, so no false kick edge
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({ss_n, interface_select, frame_length_select, output_gate, watchdog_kick,
          watchdog_period_select, parallel_inputs, junction_overheat, case_hot,
          supply_good, fb_above_90, fb_below_80, frame_tog}),
    .dout({ss_n_s, serial_s, mode16_s, gate_s, kick_s, wd_sel_s, par_s, ot_s,
           case_hot_s, supply_s, fb_high_s, fb_low_s, tog_s})
  );

  // ---- link domain, clocked by the serial clock ----

  // first rising edge of a frame, cleared by select high
  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      pos_started <= 1'b0;
    end else begin
      pos_started <= 1'b1;
    end
  end

  // sample data on the rising edge, count edges modulo eight
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_shift <= '0;
      edge_cnt <= '0;
    end else if (!ss_n) begin
      rx_shift <= {rx_shift[FRAME_BITS-2:0], sdi};
      edge_cnt <= pos_started ? edge_cnt + 3'h1 : 3'h1;
    end
  end

  // toggles once per frame that saw at least one clock edge
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frame_tog <= 1'b0;
    end else if (!ss_n && !pos_started) begin
      frame_tog <= ~frame_tog;
    end
  end

  // first falling edge of a frame, cleared by select high
  always_ff @(posedge ss_n or negedge sclk) begin
    if (ss_n) begin
      neg_started <= 1'b0;
    end else begin
      neg_started <= 1'b1;
    end
  end

  // shift out on the falling edge; received bits follow the fault bits
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      tx_shift <= '0;
    end else if (!ss_n) begin
      // the frozen word is static while select is low, safe to read here
      tx_shift <= neg_started ? {tx_shift[FRAME_BITS-2:0], rx_shift[0]}
                              : {tx_word[FRAME_BITS-2:0], rx_shift[0]};
      if (!mode16_s) begin
        tx_shift[8] <= rx_shift[0];
      end
    end
  end

  // serial output shows the frozen MSB until the first falling edge
  assign sdo_out = neg_started ? tx_shift[FRAME_BITS-1] : tx_word[FRAME_BITS-1];

  // ---- system domain ----

  // frame boundary and command decode
  assign frame_end = ss_n_s & ~ss_prev;
  assign cmd_new = mode16_s ? rx_shift[15:8] : rx_shift[7:0];
  assign cmd_par = {^(cmd_new & EVEN_LANES), ^(cmd_new & ODD_LANES), ^cmd_new,
                    ~(^cmd_new)};
  assign frame_ok = (tog_s != tog_seen) && (edge_cnt == 3'h0)
                    && (!mode16_s || (rx_shift[3:0] == cmd_par));
  assign gate_off = (gate_cnt == GATE_CNT_W'(DISABLE_HOLD_CYCLES));
  assign wd_trip = (wd_state == OSS_WD_TRIP);
  assign kick_end = kick_s & ~kick_prev;

  // edge trackers
  always_ff @(posedge clk) begin
    if (rst) begin
      ss_prev <= 1'b1;
      tog_seen <= 1'b0;
      kick_prev <= 1'b1;
    end else begin
      ss_prev <= ss_n_s;
      kick_prev <= kick_s;
      if (frame_end) begin
        tog_seen <= tog_s;
      end
    end
  end

  // output gate low time counter, saturating at the hold time
  always_ff @(posedge clk) begin
    if (rst || gate_s) begin
      gate_cnt <= '0;
    end else if (!gate_off) begin
      gate_cnt <= gate_cnt + GATE_CNT_W'(1);
    end
  end

  // channel command register, cleared by gate or watchdog until a new frame
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd <= CMD_RESET;
    end else if (gate_off || wd_trip) begin
      cmd <= CMD_RESET;
    end else if (frame_end && frame_ok && serial_s) begin
      cmd <= cmd_new;
    end
  end

  // channel drivers, overheated channels forced off
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_out <= '0;
    end else if (serial_s) begin
      channel_out <= cmd & ~ot_s & {CHANNELS{!gate_off && !wd_trip}};
    end else begin
      channel_out <= par_s & ~ot_s;
    end
  end

  // per-channel overheat flags, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_overheat_flags <= '0;
    end else begin
      channel_overheat_flags <= (frame_end ? '0 : channel_overheat_flags) | ot_s;
    end
  end

  // parity or length error status
  always_ff @(posedge clk) begin
    if (rst) begin
      parity_error_flag <= 1'b0;
    end else if (frame_end && serial_s) begin
      parity_error_flag <= !frame_ok;
    end
  end

  // regulator feedback valid tracking
  always_ff @(posedge clk) begin
    if (rst || fb_low_s) begin
      regulator_feedback_valid <= 1'b0;
    end else if (frame_end && frame_ok && fb_high_s) begin
      regulator_feedback_valid <= 1'b1;
    end
  end

  // fault frame status and parity nibble
  assign fault_status = {regulator_feedback_valid, case_hot_s, parity_error_flag,
                         supply_s};
  assign fault_par = {
    ^{supply_s, case_hot_s, channel_overheat_flags & EVEN_LANES},
    ^{parity_error_flag, regulator_feedback_valid, channel_overheat_flags & ODD_LANES},
    ^channel_overheat_flags,
    ~(^channel_overheat_flags)};

  // fault frame follows the state while idle and freezes while select is low
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_word <= '0;
    end else if (ss_n_s) begin
      tx_word <= mode16_s ? {channel_overheat_flags, fault_status, fault_par}
                          : {channel_overheat_flags, 8'h00};
    end
  end

  // serial output enable
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= !ss_n_s && serial_s;
    end
  end

  // open-drain indications, pin level is always low when driven
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_pin_oe <= 1'b0;
      warn_pin_oe <= 1'b0;
      fault_pin_out <= 1'b0;
      warn_pin_out <= 1'b0;
    end else begin
      fault_pin_oe <= (|(ot_s & (serial_s ? cmd : par_s)))
                      || (serial_s && parity_error_flag);
      warn_pin_oe <= case_hot_s;
      fault_pin_out <= 1'b0;
      warn_pin_out <= 1'b0;
    end
  end

  // watchdog timeout for the selected period
  always_comb begin
    case (wd_sel_s)
      WD_SEL_40: wd_limit = WD_CNT_W'(WD_CYCLES);
      WD_SEL_80: wd_limit = WD_CNT_W'(2 * WD_CYCLES);
      default: wd_limit = WD_CNT_W'(4 * WD_CYCLES);
    endcase
  end

  // watchdog state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_state <= OSS_WD_OFF;
      wd_cnt <= '0;
    end else begin
      case (wd_state)
        OSS_WD_OFF: begin
          wd_cnt <= '0;
          if (serial_s && wd_sel_s != WD_SEL_OFF) begin
            wd_state <= OSS_WD_RUN;
          end
        end
        OSS_WD_RUN: begin
          if (!serial_s || wd_sel_s == WD_SEL_OFF) begin
            wd_state <= OSS_WD_OFF;
          end else if (kick_end) begin
            wd_cnt <= '0;
          end else if (wd_cnt >= wd_limit - WD_CNT_W'(1)) begin
            wd_state <= OSS_WD_TRIP;
          end else begin
            wd_cnt <= wd_cnt + WD_CNT_W'(1);
          end
        end
        OSS_WD_TRIP: begin
          wd_cnt <= '0;
          if (kick_end) begin
            wd_state <= OSS_WD_RUN;
          end
        end
        default: begin
          wd_state <= OSS_WD_OFF;
          wd_cnt <= '0;
        end
      endcase
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_reset_outputs_off: assert property ($fell(rst) |-> channel_out == 8'h00)
    else $error("channels not off after reset");
  a_frame_applies: assert property (frame_end && frame_ok && serial_s && !gate_off
      && !wd_trip |=> cmd == $past(cmd_new))
    else $error("valid frame not applied");
  a_bad_frame_fault: assert property (frame_end && serial_s && !frame_ok
      |=> parity_error_flag ##1 fault_pin_oe)
    else $error("bad frame not reported");
  a_gate_forces_off: assert property (serial_s && gate_off |=> channel_out == 8'h00)
    else $error("gate did not switch outputs off");
  a_wd_forces_off: assert property (wd_trip && serial_s |=> channel_out == 8'h00)
    else $error("watchdog trip left outputs on");
  a_wd_expiry_time: assert property ($rose(wd_trip)
      |-> $past(wd_cnt) == $past(wd_limit) - 26'h0000001)
    else $error("watchdog expired at wrong count");
  a_warn_follows: assert property (warn_pin_oe == $past(case_hot_s))
    else $error("warning pin not following case heat");
  a_flags_latch: assert property (|ot_s
      |=> (channel_overheat_flags & $past(ot_s)) == $past(ot_s))
    else $error("overheat event lost");
  a_flags_clear: assert property (frame_end && ot_s == 8'h00
      |=> channel_overheat_flags == 8'h00)
    else $error("flags not cleared at frame end");
  a_sdo_released: assert property (ss_n_s |=> !sdo_oe)
    else $error("serial output driven while deselected");
  a_fb_low_clears: assert property (fb_low_s |=> !regulator_feedback_valid)
    else $error("feedback valid set while low");
endmodule : oss_ctrl

/* File: testbench/oss_host.sv */
// host model of the serial master that drives the switch's control link
`timescale 1ns/1ps
module oss_host (
  output logic sclk,
  output logic ss_n,
  output logic sdi,
  input wire logic sdo
);
  // idle link: select high, clock parked low
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    sdi = 1'b0;
  end
  // one frame of n bits, msb first, 64 ns clock only while selected
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    #0.7;
    ss_n = 1'b0;
    sdi = tx[n-1];
    #100;
    for (int i = 0; i < n; i++) begin
      #32 sclk = 1'b1;
      rx = {rx[30:0], sdo};
      #32 sclk = 1'b0;
      if (i < n - 1) begin
        sdi = tx[n-2-i];
      end
    end
    #40;
    ss_n = 1'b1;
    sdi = ~sdi; // released line shows the inverse of its last bit
  endtask : xfer
endmodule : oss_host

/* File: testbench/oss_ctrl_bench.sv */
// self-checking bench of the octal switch serial control block
`timescale 1ns/1ps
module oss_ctrl_bench;
  import oss_pkg::*;
  localparam int WD_N = 2000;
  logic clk = 1'b0, rst = 1'b0, sclk, ss_n, sdi, sdo_line, sdo_idle = 1'b0;
  logic interface_select = 1'b1, frame_length_select = 1'b0, output_gate = 1'b1;
  logic watchdog_kick = 1'b1, case_hot = 1'b0, supply_good = 1'b1;
  logic fb_above_90 = 1'b1, fb_below_80 = 1'b0;
  logic [1:0] watchdog_period_select = 2'h0;
  logic [7:0] parallel_inputs = 8'h00, junction_overheat = 8'h00;
  logic [7:0] channel_out, channel_overheat_flags, c, exp_ch = 8'h00, exp_flags = 8'h00;
  logic sdo_out, sdo_oe, fault_pin_out, fault_pin_oe, warn_pin_out, warn_pin_oe;
  logic parity_error_flag, regulator_feedback_valid, fault_n, warn_n;
  logic exp_perr = 1'b0, exp_fbv = 1'b0;
  logic [31:0] rx;
  int fails = 0, checks = 0, cycles = 0, t0, nom;
  // open-drain and tri-state wire levels seen by the host
  assign fault_n = fault_pin_oe ? fault_pin_out : 1'b1;
  assign warn_n = warn_pin_oe ? warn_pin_out : 1'b1;
  assign sdo_line = sdo_oe ? sdo_out : sdo_idle;
  always @(posedge clk) if (sdo_oe) sdo_idle <= ~sdo_out;
  always #2.5 clk = ~clk;
  oss_ctrl #(.WD_CYCLES(WD_N)) dut (.clk(clk), .rst(rst), .sclk(sclk), .ss_n(ss_n),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .interface_select(interface_select),
    .frame_length_select(frame_length_select), .output_gate(output_gate),
    .watchdog_kick(watchdog_kick), .watchdog_period_select(watchdog_period_select),
    .parallel_inputs(parallel_inputs), .junction_overheat(junction_overheat),
    .case_hot(case_hot), .supply_good(supply_good), .fb_above_90(fb_above_90),
    .fb_below_80(fb_below_80), .channel_out(channel_out), .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe), .warn_pin_out(warn_pin_out), .warn_pin_oe(warn_pin_oe),
    .channel_overheat_flags(channel_overheat_flags), .parity_error_flag(parity_error_flag),
    .regulator_feedback_valid(regulator_feedback_valid));
  oss_host host (.sclk(sclk), .ss_n(ss_n), .sdi(sdi), .sdo(sdo_line));
  // command word with its parity nibble
  function automatic logic [15:0] cw16(input logic [7:0] v);
    return {v, 4'h0, ^(v & EVEN_LANES), ^(v & ODD_LANES), ^v, ~^v};
  endfunction : cw16
  // expected 16-bit fault frame
  function automatic logic [15:0] ff16(input logic [7:0] f, input logic fbv, input logic w,
      input logic pe, input logic sg);
    return {f, fbv, w, pe, sg, ^{sg, w, f & EVEN_LANES}, ^{pe, fbv, f & ODD_LANES}, ^f, ~^f};
  endfunction : ff16
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic frame(input logic [31:0] tx, input int n);
    host.xfer(tx, n, rx);
    tick(20);
  endtask : frame
  // well-formed frame in the current mode, fault frame and outputs compared
  task automatic good(input logic [7:0] v);
    logic [31:0] ef;
    ef = frame_length_select ? {16'h0, ff16(exp_flags, exp_fbv, case_hot, exp_perr, supply_good)}
                             : {24'h0, exp_flags};
    if (frame_length_select) frame(cw16(v), 16);
    else frame({24'h0, v}, 8);
    exp_ch = v;
    exp_perr = 1'b0;
    exp_fbv = fb_above_90 & ~fb_below_80;
    exp_flags = 8'h00;
    chk("fault_frame", rx, ef);
    chk("channel_out", channel_out, exp_ch);
    chk("parity_error_flag", parity_error_flag, 1'b0);
    chk("feedback_valid", regulator_feedback_valid, exp_fbv);
    chk("overheat_flags", channel_overheat_flags, 8'h00);
  endtask : good
  task automatic kick;
    watchdog_kick = 1'b0;
    tick(10);
    watchdog_kick = 1'b1;
  endtask : kick
  initial begin
    #1 rst = 1'b1; // a real rising edge, so the link-side registers clear as well
    void'($urandom(32'hACE5));
    tick(5);
    rst = 1'b0;
    chk("reset_out", channel_out, 8'h00);
    chk("reset_flags", channel_overheat_flags, 8'h00);
    chk("sdo_oe_idle", sdo_oe, 1'b0);
    chk("reset_fbv", regulator_feedback_valid, 1'b0);
    tick(10);
    // 8-bit frames, corners then random
    for (int k = 0; k < 10; k++) begin
      c = (k == 0) ? 8'h01 : (k == 1) ? 8'hFF : 8'($urandom);
      good(c);
    end
    // long frame: last byte evaluated, earlier bits echoed after the faults
    c = 8'($urandom);
    frame({8'h0, 8'hA5, 8'h3C, c}, 24);
    chk("long_out", channel_out, c);
    chk("long_echo", rx, {8'h0, exp_flags, 16'hA53C});
    exp_ch = c;
    // 12 edges: refused
    frame(32'hF0F, 12);
    chk("len_out", channel_out, exp_ch);
    chk("len_perr", parity_error_flag, 1'b1);
    chk("len_fault", fault_n, 1'b0);
    exp_perr = 1'b1;
    // 16-bit frames with random supply status
    frame_length_select = 1'b1;
    tick(10);
    for (int k = 0; k < 8; k++) begin
      supply_good = 1'($urandom);
      c = 8'($urandom);
      tick(10);
      good(c);
    end
    // corrupted parity nibble
    frame({16'h0, cw16(8'h3C) ^ 16'h0001}, 16);
    chk("par_out", channel_out, exp_ch);
    chk("par_perr", parity_error_flag, 1'b1);
    exp_perr = 1'b1;
    // feedback drop, recovery needs a good frame
    fb_below_80 = 1'b1;
    tick(10);
    chk("fbv_low", regulator_feedback_valid, 1'b0);
    fb_below_80 = 1'b0;
    exp_fbv = 1'b0;
    tick(10);
    chk("fbv_wait", regulator_feedback_valid, 1'b0);
    good(8'hFF);
    // junction overheat latches, pin follows the condition
    junction_overheat = 8'h04;
    tick(10);
    chk("ovt_flag", channel_overheat_flags, 8'h04);
    chk("ovt_fault", fault_n, 1'b0);
    junction_overheat = 8'h00;
    tick(10);
    chk("ovt_release", fault_n, 1'b1);
    chk("ovt_latched", channel_overheat_flags, 8'h04);
    exp_flags = 8'h04;
    good(8'h5A);
    // case warning, not latched
    case_hot = 1'b1;
    tick(10);
    chk("warn_on", warn_n, 1'b0);
    good(8'h11);
    case_hot = 1'b0;
    tick(10);
    chk("warn_off", warn_n, 1'b1);
    // output gate disable and re-enable
    output_gate = 1'b0;
    tick(150);
    chk("gate_early", channel_out, 8'h11);
    tick(80);
    chk("gate_off", channel_out, 8'h00);
    // link still answers while gated, but the frame must not switch anything on
    frame({16'h0, cw16(8'h22)}, 16);
    chk("gate_frame", rx, {16'h0, ff16(8'h00, exp_fbv, 1'b0, 1'b0, supply_good)});
    chk("gate_perr", parity_error_flag, 1'b0);
    chk("gate_held", channel_out, 8'h00);
    output_gate = 1'b1;
    tick(10);
    chk("gate_stays", channel_out, 8'h00);
    good(8'h22);
    // watchdog periods, trip and restart
    for (int k = 1; k < 4; k++) begin
      watchdog_period_select = 2'(k);
      kick();
      t0 = cycles;
      nom = WD_N << (k - 1);
      good(8'hF0);
      while (channel_out !== 8'h00 && cycles - t0 < 12000) tick(1);
      chk("wd_time", (cycles - t0 >= nom * 3 / 4) && (cycles - t0 <= nom * 5 / 4), 1);
      frame({16'h0, cw16(8'h0F)}, 16);
      chk("wd_held", channel_out, 8'h00);
    end
    watchdog_period_select = WD_SEL_OFF;
    kick();
    good(8'h0F);
    tick(WD_N * 2);
    chk("wd_off", channel_out, 8'h0F);
    // parallel mode
    interface_select = 1'b0;
    for (int k = 0; k < 4; k++) begin
      parallel_inputs = 8'($urandom);
      junction_overheat = 8'($urandom);
      tick(10);
      chk("par_mode", channel_out, parallel_inputs & ~junction_overheat);
      chk("par_sdo", sdo_oe, 1'b0);
    end
    end_of_test();
  end
endmodule : oss_ctrl_bench
